// ==== src/drc_params.svh ====
// Constants of the drive run command and status block
`ifndef DRC_PARAMS_SVH
`define DRC_PARAMS_SVH
// ----------------------------------------------------------------
// Attribute path
// ----------------------------------------------------------------
`define DRC_CLASS_ID 8'h64
`define DRC_INST_ID 8'h01
// ----------------------------------------------------------------
// Parameter (attribute) numbers
// ----------------------------------------------------------------
`define DRC_PAR_CTRL 8'h03
`define DRC_PAR_TARGET 8'h04
`define DRC_PAR_STATUS 8'h08
`define DRC_PAR_SPEED 8'h09
`define DRC_PAR_POS 8'h0A
`define DRC_PAR_TORQ 8'h0E
`define DRC_PAR_PEAK 8'h0F
`define DRC_PAR_ULOG 8'h10
`define DRC_PAR_UMOT 8'h11
`define DRC_PAR_TEMP 8'h12
`define DRC_PAR_SWITCH 8'h13
`define DRC_PAR_DATE 8'h14
`define DRC_PAR_SERIAL 8'h15
`define DRC_CFG_FIRST 8'h1A
`define DRC_CFG_LAST 8'h6E
`define DRC_CFG_EN_FIRST 8'h19
`define DRC_CFG_EN_LAST 8'h6D
`define DRC_CFG_EN_BIT 0
// ----------------------------------------------------------------
// Control and status word
// ----------------------------------------------------------------
`define DRC_CTRL_UP 0
`define DRC_CTRL_DN 1
`define DRC_CTRL_XFER 2
`define DRC_CTRL_REL 4
`define DRC_CTRL_MASK 16'h0017
`define DRC_CTRL_MANUAL_CLR 16'hFFFC
`define DRC_STAT_RSVD_MASK 16'hFFF3
// ----------------------------------------------------------------
// Assembly layout, both assemblies 16 bytes
// ----------------------------------------------------------------
`define DRC_ASM_W 128
`define DRC_OA_CTRL_LSB 0
`define DRC_OA_TGT_LSB 16
`define DRC_OA_PI_LSB 48
`define DRC_PI_REQ_W 80
`define DRC_PI_RSP_W 64
// ----------------------------------------------------------------
// Access answer codes
// ----------------------------------------------------------------
`define DRC_RSP_OK 8'h00
`define DRC_RSP_BAD_PATH 8'h05
`define DRC_RSP_STATE 8'h0C
`define DRC_RSP_READ_ONLY 8'h0E
`define DRC_RSP_BAD_ATTR 8'h14
// ----------------------------------------------------------------
// Parameter store
// ----------------------------------------------------------------
`define DRC_MEM_AW 7
`define DRC_MEM_DEPTH 128
`endif

// ==== src/drc_pkg.sv ====
// Types of the drive run command and status block
package drc_pkg;
  // ----------------------------------------------------------------
  // Explicit access sequencer
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    DRC_IDLE = 3'b001,
    DRC_LOOK = 3'b010,
    DRC_RESP = 3'b100
  } drc_acc_t;

  typedef struct packed {
    drc_acc_t acc;
    logic [7:0] att;
    logic wr;
    logic [7:0] code;
    logic [7:0] rsp_status;
    logic [31:0] rsp_data;
    logic [15:0] ctrl;
    logic [31:0] target;
    logic go;
    logic reref;
    logic [31:0] reref_val;
    logic cyc_tx_valid;
    logic [127:0] cyc_tx_block;
    logic pi_req_valid;
    logic [79:0] pi_req;
    logic en_pend;
    logic [7:0] en_param;
    logic en_bit;
    logic nv_valid;
    logic [7:0] nv_param;
    logic [31:0] nv_data;
    logic [15:0] sw_meta;
    logic [15:0] sw_sync;
  } drc_state_t;

  typedef struct packed {
    logic was_running;
    logic [15:0] peak;
  } drc_peak_t;

  typedef struct packed {
    logic [127:0][31:0] mem;
    logic [31:0] rdata;
  } drc_store_t;
endpackage : drc_pkg

// ==== src/drc_param_store.sv ====
// Storage for the configurable parameter block
`timescale 1ns/100ps
`include "drc_params.svh"
module drc_param_store
  import drc_pkg::*;
(
  // Clock
  input wire logic clk_in,
  // Write port
  input wire logic we_in,
  input wire logic [6:0] waddr_in,
  input wire logic [31:0] wdata_in,
  // Read port, data one cycle later
  input wire logic [6:0] raddr_in,
  output logic [31:0] rdata_out
);
  drc_store_t st;
  drc_store_t next_st;

  // Contents come from the nonvolatile reload, so no reset here
  always_comb begin
    next_st = st;
    next_st.rdata = st.mem[raddr_in];
    if (we_in) begin
      next_st.mem[waddr_in] = wdata_in;
    end
  end

  always_ff @(posedge clk_in) begin
    st <= next_st;
  end

  assign rdata_out = st.rdata;
endmodule : drc_param_store

// ==== src/drc_peak_torque.sv ====
// Peak torque tracker for the latest run
`timescale 1ns/100ps
`include "drc_params.svh"
module drc_peak_torque
  import drc_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Motion phase
  input wire logic running_in,
  input wire logic start_phase_in,
  input wire logic braking_in,
  input wire logic [15:0] torque_in,
  // Result
  output logic [15:0] peak_out
);
  drc_peak_t st;
  drc_peak_t next_st;
  logic track;

  assign track = running_in && !start_phase_in && !braking_in;

  always_comb begin
    next_st = st;
    next_st.was_running = running_in;
    // A new run restarts the peak; the last value stays readable after it
    if (running_in && !st.was_running) begin
      next_st.peak = 16'h0000;
    end else if (track && (torque_in > st.peak)) begin
      next_st.peak = torque_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign peak_out = st.peak;

  AST_PEAK_HOLD: assert property (@(posedge clk_in) disable iff (rst_in)
    (st.was_running && (start_phase_in || braking_in)) |=> (peak_out == $past(peak_out)))
    else $error("peak torque moved during start or braking phase");
endmodule : drc_peak_torque

// ==== src/drc_drive_run_command_status.sv ====
// Command decoder, cyclic assemblies and parameter access of the drive
`timescale 1ns/100ps
`include "drc_params.svh"
module drc_drive_run_command_status
  import drc_pkg::*;
(
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Cyclic connection
  input wire logic conn_active_in,
  input wire logic cyc_rx_valid_in,
  input wire logic [127:0] cyc_rx_block_in,
  output logic cyc_tx_valid_out,
  output logic [127:0] cyc_tx_block_out,
  // Parameter interface channel inside the assemblies
  output logic pi_req_valid_out,
  output logic [79:0] pi_req_out,
  input wire logic [63:0] pi_rsp_in,
  // Configuration at connection setup
  input wire logic cfg_valid_in,
  input wire logic [7:0] cfg_param_in,
  input wire logic [31:0] cfg_data_in,
  // Explicit attribute access
  input wire logic acc_valid_in,
  output logic acc_ready_out,
  input wire logic acc_write_in,
  input wire logic [7:0] acc_class_in,
  input wire logic [7:0] acc_instance_in,
  input wire logic [7:0] acc_attr_in,
  input wire logic [31:0] acc_data_in,
  output logic acc_rsp_valid_out,
  output logic [7:0] acc_rsp_status_out,
  output logic [31:0] acc_rsp_data_out,
  // Nonvolatile storage link
  input wire logic nv_load_valid_in,
  input wire logic [7:0] nv_load_param_in,
  input wire logic [31:0] nv_load_data_in,
  output logic nv_store_valid_out,
  output logic [7:0] nv_store_param_out,
  output logic [31:0] nv_store_data_out,
  // Measurements from the motion core
  input wire logic [15:0] status_flags_in,
  input wire logic [15:0] speed_in,
  input wire logic [31:0] position_in,
  input wire logic [15:0] torque_in,
  input wire logic running_in,
  input wire logic start_phase_in,
  input wire logic braking_in,
  input wire logic standstill_in,
  input wire logic [15:0] logic_supply_in,
  input wire logic [15:0] drive_supply_in,
  input wire logic [15:0] temperature_in,
  input wire logic [15:0] switch_pins_in,
  input wire logic [15:0] build_date_in,
  input wire logic [15:0] serial_in,
  // Commands to the motion core
  output logic [15:0] ctrl_word_out,
  output logic manual_up_out,
  output logic manual_down_out,
  output logic release_out,
  output logic [31:0] target_out,
  output logic target_go_out,
  output logic reref_out,
  output logic [31:0] reref_value_out
);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic in_cfg(input logic [7:0] attr);
    in_cfg = (attr >= `DRC_CFG_FIRST) && (attr <= `DRC_CFG_LAST);
  endfunction : in_cfg

  function automatic logic [6:0] cfg_index(input logic [7:0] attr);
    logic [7:0] diff;
    diff = attr - `DRC_CFG_FIRST;
    cfg_index = diff[6:0];
  endfunction : cfg_index

  function automatic logic is_ro(input logic [7:0] attr);
    unique case (attr)
      `DRC_PAR_STATUS, `DRC_PAR_SPEED, `DRC_PAR_TORQ, `DRC_PAR_PEAK, `DRC_PAR_ULOG,
      `DRC_PAR_UMOT, `DRC_PAR_TEMP, `DRC_PAR_SWITCH, `DRC_PAR_DATE, `DRC_PAR_SERIAL: is_ro = 1'b1;
      default: is_ro = 1'b0;
    endcase
  endfunction : is_ro

  // ----------------------------------------------------------------
  // State and datapath
  // ----------------------------------------------------------------
  drc_state_t st;
  drc_state_t next_st;
  logic take;
  logic [15:0] rx_cw;
  logic [31:0] rx_tgt;
  logic [15:0] status_word;
  logic [15:0] peak;
  logic mem_we;
  logic [6:0] mem_waddr;
  logic [31:0] mem_wdata;
  logic [6:0] mem_raddr;
  logic [31:0] mem_rdata;

  // Access waits while setup or reload owns the store write port
  assign acc_ready_out = (st.acc == DRC_IDLE) && !cfg_valid_in && !nv_load_valid_in;
  assign take = acc_valid_in && acc_ready_out;
  assign rx_cw = cyc_rx_block_in[`DRC_OA_CTRL_LSB +: 16];
  assign rx_tgt = cyc_rx_block_in[`DRC_OA_TGT_LSB +: 32];
  assign status_word = status_flags_in & `DRC_STAT_RSVD_MASK;

  drc_param_store u_store (
    .clk_in(clk_in),
    .we_in(mem_we),
    .waddr_in(mem_waddr),
    .wdata_in(mem_wdata),
    .raddr_in(mem_raddr),
    .rdata_out(mem_rdata)
  );

  drc_peak_torque u_peak (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .running_in(running_in),
    .start_phase_in(start_phase_in),
    .braking_in(braking_in),
    .torque_in(torque_in),
    .peak_out(peak)
  );

  always_comb begin
    next_st = st;
    next_st.go = 1'b0;
    next_st.reref = 1'b0;
    next_st.cyc_tx_valid = 1'b0;
    next_st.pi_req_valid = 1'b0;
    next_st.nv_valid = 1'b0;
    next_st.sw_meta = switch_pins_in;
    next_st.sw_sync = st.sw_meta;
    mem_we = 1'b0;
    mem_waddr = cfg_index(nv_load_param_in);
    mem_wdata = nv_load_data_in;
    mem_raddr = cfg_index(acc_attr_in);
    // ----------------------------------------------------------------
    // Cyclic exchange
    // ----------------------------------------------------------------
    if (cyc_rx_valid_in) begin
      next_st.ctrl = rx_cw & `DRC_CTRL_MASK;
      if (rx_cw[`DRC_CTRL_XFER]) begin
        next_st.target = rx_tgt;
        next_st.go = 1'b1;
      end
      next_st.pi_req = cyc_rx_block_in[`DRC_OA_PI_LSB +: `DRC_PI_REQ_W];
      next_st.pi_req_valid = 1'b1;
      next_st.cyc_tx_valid = 1'b1;
      next_st.cyc_tx_block = {pi_rsp_in, position_in, speed_in, status_word};
    end
    // ----------------------------------------------------------------
    // Nonvolatile reload, then connection setup pairs
    // ----------------------------------------------------------------
    if (nv_load_valid_in && in_cfg(nv_load_param_in)) begin
      mem_we = 1'b1;
    end
    if (cfg_valid_in) begin
      if (!st.en_pend) begin
        // An enable entry announces the value entry that follows it
        next_st.en_pend = (cfg_param_in >= `DRC_CFG_EN_FIRST) && (cfg_param_in <= `DRC_CFG_EN_LAST);
        next_st.en_param = cfg_param_in;
        next_st.en_bit = cfg_data_in[`DRC_CFG_EN_BIT];
      end else begin
        next_st.en_pend = 1'b0;
        if (st.en_bit && (cfg_param_in == st.en_param + 8'h01) && in_cfg(cfg_param_in)) begin
          mem_we = 1'b1;
          mem_waddr = cfg_index(cfg_param_in);
          mem_wdata = cfg_data_in;
          next_st.nv_valid = 1'b1;
          next_st.nv_param = cfg_param_in;
          next_st.nv_data = cfg_data_in;
        end
      end
    end
    // ----------------------------------------------------------------
    // Explicit attribute access
    // ----------------------------------------------------------------
    unique case (st.acc)
      DRC_IDLE: begin
        if (take) begin
          next_st.att = acc_attr_in;
          next_st.wr = acc_write_in;
          next_st.code = `DRC_RSP_OK;
          next_st.acc = DRC_LOOK;
          if ((acc_class_in != `DRC_CLASS_ID) || (acc_instance_in != `DRC_INST_ID)) begin
            next_st.code = `DRC_RSP_BAD_PATH;
          end else if (!acc_write_in) begin
            if (!(is_ro(acc_attr_in) || in_cfg(acc_attr_in) || (acc_attr_in == `DRC_PAR_CTRL) ||
                  (acc_attr_in == `DRC_PAR_TARGET) || (acc_attr_in == `DRC_PAR_POS))) begin
              next_st.code = `DRC_RSP_BAD_ATTR;
            end
          end else if ((acc_attr_in == `DRC_PAR_CTRL) || (acc_attr_in == `DRC_PAR_TARGET)) begin
            if (conn_active_in) begin
              next_st.code = `DRC_RSP_STATE;
            end else if (acc_attr_in == `DRC_PAR_CTRL) begin
              next_st.ctrl = acc_data_in[15:0] & `DRC_CTRL_MASK;
            end else begin
              next_st.target = acc_data_in;
              next_st.ctrl = st.ctrl & `DRC_CTRL_MANUAL_CLR;
              next_st.go = 1'b1;
            end
          end else if (acc_attr_in == `DRC_PAR_POS) begin
            if (standstill_in) begin
              next_st.reref = 1'b1;
              next_st.reref_val = acc_data_in;
            end else begin
              next_st.code = `DRC_RSP_STATE;
            end
          end else if (in_cfg(acc_attr_in)) begin
            mem_we = 1'b1;
            mem_waddr = cfg_index(acc_attr_in);
            mem_wdata = acc_data_in;
            next_st.nv_valid = 1'b1;
            next_st.nv_param = acc_attr_in;
            next_st.nv_data = acc_data_in;
          end else if (is_ro(acc_attr_in)) begin
            next_st.code = `DRC_RSP_READ_ONLY;
          end else begin
            next_st.code = `DRC_RSP_BAD_ATTR;
          end
        end
      end
      DRC_LOOK: begin
        next_st.rsp_status = st.code;
        next_st.rsp_data = 32'h0000_0000;
        if (!st.wr && (st.code == `DRC_RSP_OK)) begin
          unique case (st.att)
            `DRC_PAR_CTRL: next_st.rsp_data = {16'h0000, st.ctrl};
            `DRC_PAR_TARGET: next_st.rsp_data = st.target;
            `DRC_PAR_STATUS: next_st.rsp_data = {16'h0000, status_word};
            `DRC_PAR_SPEED: next_st.rsp_data = {{16{speed_in[15]}}, speed_in};
            `DRC_PAR_POS: next_st.rsp_data = position_in;
            `DRC_PAR_TORQ: next_st.rsp_data = {16'h0000, torque_in};
            `DRC_PAR_PEAK: next_st.rsp_data = {16'h0000, peak};
            `DRC_PAR_ULOG: next_st.rsp_data = {16'h0000, logic_supply_in};
            `DRC_PAR_UMOT: next_st.rsp_data = {16'h0000, drive_supply_in};
            `DRC_PAR_TEMP: next_st.rsp_data = {16'h0000, temperature_in};
            `DRC_PAR_SWITCH: next_st.rsp_data = {16'h0000, st.sw_sync};
            `DRC_PAR_DATE: next_st.rsp_data = {16'h0000, build_date_in};
            `DRC_PAR_SERIAL: next_st.rsp_data = {16'h0000, serial_in};
            default: next_st.rsp_data = mem_rdata;
          endcase
        end
        next_st.acc = DRC_RESP;
      end
      DRC_RESP: begin
        next_st.acc = DRC_IDLE;
      end
      default: begin
        next_st.acc = DRC_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      st <= '0;
      st.acc <= DRC_IDLE;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Opposite manual bits together mean no run rather than a guess
  assign manual_up_out = st.ctrl[`DRC_CTRL_REL] && st.ctrl[`DRC_CTRL_UP] && !st.ctrl[`DRC_CTRL_DN];
  assign manual_down_out = st.ctrl[`DRC_CTRL_REL] && st.ctrl[`DRC_CTRL_DN] && !st.ctrl[`DRC_CTRL_UP];
  assign release_out = st.ctrl[`DRC_CTRL_REL];
  assign ctrl_word_out = st.ctrl;
  assign target_out = st.target;
  assign target_go_out = st.go;
  assign reref_out = st.reref;
  assign reref_value_out = st.reref_val;
  assign cyc_tx_valid_out = st.cyc_tx_valid;
  assign cyc_tx_block_out = st.cyc_tx_block;
  assign pi_req_valid_out = st.pi_req_valid;
  assign pi_req_out = st.pi_req;
  assign acc_rsp_valid_out = (st.acc == DRC_RESP);
  assign acc_rsp_status_out = st.rsp_status;
  assign acc_rsp_data_out = st.rsp_data;
  assign nv_store_valid_out = st.nv_valid;
  assign nv_store_param_out = st.nv_param;
  assign nv_store_data_out = st.nv_data;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_write(logic [7:0] attr);
    take && acc_write_in && (acc_class_in == `DRC_CLASS_ID) && (acc_instance_in == `DRC_INST_ID) &&
      (acc_attr_in == attr);
  endsequence

  AST_MANUAL_START: assert property (@(posedge clk_in) disable iff (rst_in)
    (cyc_rx_valid_in && (rx_cw == 16'h0011)) |=> (manual_up_out && !manual_down_out))
    else $error("manual run did not start");
  AST_MANUAL_END: assert property (@(posedge clk_in) disable iff (rst_in)
    (cyc_rx_valid_in && ((rx_cw == 16'h0010) || (rx_cw == 16'h0000))) |=> (!manual_up_out && !manual_down_out))
    else $error("manual run did not end");
  AST_CYC_TARGET: assert property (@(posedge clk_in) disable iff (rst_in)
    (cyc_rx_valid_in && (rx_cw == 16'h0014)) |=> (target_go_out && !manual_up_out && (target_out == $past(rx_tgt))))
    else $error("cyclic target not taken");
  AST_EXPL_TARGET: assert property (@(posedge clk_in) disable iff (rst_in)
    (s_write(`DRC_PAR_TARGET) and (!conn_active_in && !cyc_rx_valid_in)) |=>
      ((ctrl_word_out[1:0] == 2'b00) && target_go_out) ##1 (acc_rsp_valid_out && (acc_rsp_status_out == `DRC_RSP_OK)))
    else $error("explicit target did not clear manual bits");
  AST_CONN_REJECT: assert property (@(posedge clk_in) disable iff (rst_in)
    (s_write(`DRC_PAR_CTRL) and (conn_active_in && !cyc_rx_valid_in)) |=>
      ($stable(ctrl_word_out) ##1 (acc_rsp_valid_out && (acc_rsp_status_out == `DRC_RSP_STATE))))
    else $error("control write accepted during connection");
  AST_BAD_PATH: assert property (@(posedge clk_in) disable iff (rst_in)
    (take && (acc_class_in != `DRC_CLASS_ID)) |-> ##2 (acc_rsp_valid_out && (acc_rsp_status_out == `DRC_RSP_BAD_PATH)))
    else $error("wrong class not refused");
  AST_REREF: assert property (@(posedge clk_in) disable iff (rst_in)
    (s_write(`DRC_PAR_POS) and !standstill_in) |=> !reref_out ##1 (acc_rsp_status_out == `DRC_RSP_STATE))
    else $error("position re-referenced while moving");
  AST_REREF_GO: assert property (@(posedge clk_in) disable iff (rst_in)
    (s_write(`DRC_PAR_POS) and standstill_in) |=> (reref_out && (reref_value_out == $past(acc_data_in))))
    else $error("position not re-referenced at standstill");
  AST_TX_FRAME: assert property (@(posedge clk_in) disable iff (rst_in)
    cyc_rx_valid_in |=> (cyc_tx_valid_out && (cyc_tx_block_out[3:2] == 2'b00) &&
      (cyc_tx_block_out[63:32] == $past(position_in))))
    else $error("input assembly wrong");
  AST_CFG_SKIP: assert property (@(posedge clk_in) disable iff (rst_in)
    (cfg_valid_in && !st.en_pend && (cfg_param_in >= `DRC_CFG_EN_FIRST) && (cfg_param_in <= `DRC_CFG_EN_LAST) &&
      !cfg_data_in[0]) ##1 cfg_valid_in |=> !nv_store_valid_out)
    else $error("disabled configuration value taken");
endmodule : drc_drive_run_command_status

// ==== testbench/drc_scanner_model.sv ====
// Scanner model that sends cyclic output blocks
`timescale 1ns/100ps
module drc_scanner_model (
  // Clock
  input wire logic clk_in,
  // Cyclic output block
  output logic cyc_rx_valid_out,
  output logic [127:0] cyc_rx_block_out
);
  initial begin
    cyc_rx_valid_out = 1'b0;
    cyc_rx_block_out = '0;
  end
  // Block is inverted once released, so a stale frame is never read back as valid data
  task automatic send(input logic [15:0] cw, input logic [31:0] tg, input logic [79:0] rq);
    @(posedge clk_in);
    cyc_rx_valid_out <= 1'b1;
    cyc_rx_block_out <= {rq, tg, cw};
    @(posedge clk_in);
    cyc_rx_valid_out <= 1'b0;
    cyc_rx_block_out <= ~{rq, tg, cw};
  endtask : send
endmodule : drc_scanner_model

// ==== testbench/tb.sv ====
// Self-checking testbench of the drive run command and status block
`timescale 1ns/100ps
module tb;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic clk_in, rst_in, conn_active_in, cyc_rx_valid_in, cyc_tx_valid_out, pi_req_valid_out, cfg_valid_in;
  logic acc_valid_in, acc_ready_out, acc_write_in, acc_rsp_valid_out, nv_load_valid_in, nv_store_valid_out;
  logic running_in, start_phase_in, braking_in, standstill_in, manual_up_out, manual_down_out, release_out;
  logic target_go_out, reref_out;
  logic [7:0] cfg_param_in, acc_class_in, acc_instance_in, acc_attr_in, acc_rsp_status_out, nv_load_param_in;
  logic [7:0] nv_store_param_out, st;
  logic [15:0] status_flags_in, speed_in, torque_in, logic_supply_in, drive_supply_in, temperature_in;
  logic [15:0] switch_pins_in, build_date_in, serial_in, ctrl_word_out;
  logic [31:0] cfg_data_in, acc_data_in, acc_rsp_data_out, nv_load_data_in, nv_store_data_out, position_in;
  logic [31:0] target_out, reref_value_out, rd;
  logic [63:0] pi_rsp_in;
  logic [79:0] pi_req_out;
  logic [127:0] cyc_rx_block_in, cyc_tx_block_out;
  logic [15:0] meas [6] = '{16'h00F0, 16'h00F1, 16'h0019, 16'h0007, 16'h0906, 16'h1234};
  int errors, n_compared, cycles;
  drc_drive_run_command_status drc_drive_run_command_status_inst (.*);
  drc_scanner_model drc_scanner_model_inst (.clk_in(clk_in), .cyc_rx_valid_out(cyc_rx_valid_in),
    .cyc_rx_block_out(cyc_rx_block_in));
  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end
  // Whole run needs well under 1000 cycles
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      errors++;
      give_verdict();
    end
  end
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [127:0] got, input logic [127:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : give_verdict
  task automatic snd(input logic [15:0] cw, input logic [31:0] tg);
    drc_scanner_model_inst.send(cw, tg, 80'h1234);
    #1;
  endtask : snd
  task automatic acc(input logic wr, input logic [7:0] cl, ins, at, input logic [31:0] d);
    int n;
    @(posedge clk_in);
    {acc_valid_in, acc_write_in} <= {1'b1, wr};
    {acc_class_in, acc_instance_in, acc_attr_in, acc_data_in} <= {cl, ins, at, d};
    n = 0;
    @(posedge clk_in);
    while (acc_ready_out !== 1'b1 && n < 20) begin
      @(posedge clk_in);
      n++;
    end
    acc_valid_in <= 1'b0;
    n = 0;
    do begin
      @(posedge clk_in);
      #1;
      n++;
    end while (acc_rsp_valid_out !== 1'b1 && n < 4);
    chk(acc_rsp_valid_out, 1'b1, "answer");
    st = acc_rsp_status_out;
    rd = acc_rsp_data_out;
  endtask : acc
  task automatic cfg(input logic [7:0] p, input logic en, input logic [31:0] v);
    @(posedge clk_in);
    {cfg_valid_in, cfg_param_in, cfg_data_in} <= {1'b1, p - 8'h01, 31'h0, en};
    @(posedge clk_in);
    {cfg_param_in, cfg_data_in} <= {p, v};
    @(posedge clk_in);
    cfg_valid_in <= 1'b0;
    #1;
    chk(nv_store_valid_out, en, "store pulse");
    if (en) chk({nv_store_param_out, nv_store_data_out}, {p, v}, "stored value");
  endtask : cfg
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic test_cyclic();
    @(posedge clk_in);
    conn_active_in <= 1'b1;
    snd(16'h0011, 32'h0);
    chk({manual_up_out, manual_down_out, release_out}, 3'b101, "run up");
    chk({cyc_tx_valid_out, pi_req_valid_out}, 2'b11, "pulses");
    chk(cyc_tx_block_out, {pi_rsp_in, position_in, speed_in, 16'hFFF3}, "input block");
    chk(pi_req_out, 80'h1234, "request");
    snd(16'h0012, 32'h0);
    chk({manual_up_out, manual_down_out, release_out}, 3'b011, "run down");
    snd(16'h8010, 32'h0);
    chk({manual_down_out, release_out, ctrl_word_out}, {2'b01, 16'h0010}, "stop");
    snd(16'h0011, 32'h0);
    snd(16'h0014, 32'h0000_4E20);
    chk({manual_up_out, target_go_out, target_out}, {2'b01, 32'h4E20}, "target");
    snd(16'h0011, 32'h0);
    snd(16'h0000, 32'h0);
    chk({manual_up_out, release_out}, 2'b00, "release off");
    $display("test cyclic done");
  endtask : test_cyclic
  task automatic test_access();
    acc(0, 8'h64, 8'h01, 8'h08, 0);
    chk({st, rd}, {8'h00, 32'hFFF3}, "status");
    acc(1, 8'h64, 8'h01, 8'h03, 32'h11);
    chk({st, ctrl_word_out}, {8'h0C, 16'h0}, "ctrl connected");
    acc(0, 8'h65, 8'h01, 8'h08, 0);
    chk(st, 8'h05, "class");
    acc(0, 8'h64, 8'h02, 8'h08, 0);
    chk(st, 8'h05, "instance");
    acc(1, 8'h64, 8'h01, 8'h08, 1);
    chk(st, 8'h0E, "read only");
    acc(0, 8'h64, 8'h01, 8'hF0, 0);
    chk(st, 8'h14, "unknown");
    acc(0, 8'h64, 8'h01, 8'h09, 0);
    chk(rd, 32'hFFFF8001, "speed");
    for (int i = 0; i < 6; i++) begin
      acc(0, 8'h64, 8'h01, 8'h10 + 8'(i), 0);
      chk({st, rd}, {8'h00, 16'h0, meas[i]}, "measure");
    end
    acc(0, 8'h64, 8'h01, 8'h0A, 0);
    chk(rd, position_in, "position");
    @(posedge clk_in);
    {conn_active_in, standstill_in} <= 2'b00;
    acc(1, 8'h64, 8'h01, 8'h03, 32'h11);
    chk({st, manual_up_out}, {8'h00, 1'b1}, "explicit run");
    acc(1, 8'h64, 8'h01, 8'h04, 32'h100);
    chk({st, ctrl_word_out, target_out}, {8'h00, 16'h0010, 32'h100}, "explicit target");
    acc(1, 8'h64, 8'h01, 8'h0A, 32'h77);
    chk({st, reref_value_out}, {8'h0C, 32'h0}, "moving");
    @(posedge clk_in);
    standstill_in <= 1'b1;
    acc(1, 8'h64, 8'h01, 8'h0A, 32'h77);
    chk({st, reref_value_out}, {8'h00, 32'h77}, "standstill");
    $display("test access done");
  endtask : test_access
  task automatic test_config();
    cfg(8'h1A, 1'b1, 32'h1);
    cfg(8'h1A, 1'b0, 32'h0);
    acc(0, 8'h64, 8'h01, 8'h1A, 0);
    chk(rd, 32'h1, "kept");
    cfg(8'h6E, 1'b1, 32'hABCD);
    @(posedge clk_in);
    {nv_load_valid_in, nv_load_param_in, nv_load_data_in} <= {1'b1, 8'h1B, 32'h5555};
    @(posedge clk_in);
    nv_load_valid_in <= 1'b0;
    acc(0, 8'h64, 8'h01, 8'h1B, 0);
    chk(rd, 32'h5555, "restored");
    $display("test config done");
  endtask : test_config
  // Braking torque is larger than the tracked value, so a leak into the peak shows
  task automatic test_peak();
    @(posedge clk_in);
    {running_in, start_phase_in, torque_in} <= {2'b11, 16'h0900};
    @(posedge clk_in);
    {start_phase_in, torque_in} <= {1'b0, 16'h0050};
    @(posedge clk_in);
    {braking_in, torque_in} <= {1'b1, 16'h0700};
    @(posedge clk_in);
    {running_in, braking_in} <= 2'b00;
    acc(0, 8'h64, 8'h01, 8'h0F, 0);
    chk({st, rd}, {8'h00, 32'h50}, "peak");
    acc(0, 8'h64, 8'h01, 8'h0E, 0);
    chk({st, rd}, {8'h00, 32'h700}, "torque");
    $display("test peak done");
  endtask : test_peak
  initial begin
    rst_in = 1'b1;
    {conn_active_in, cfg_valid_in, acc_valid_in, acc_write_in, nv_load_valid_in} = '0;
    {running_in, start_phase_in, braking_in, standstill_in} = 4'b0001;
    {cfg_param_in, cfg_data_in, acc_class_in, acc_instance_in, acc_attr_in, acc_data_in} = '0;
    {nv_load_param_in, nv_load_data_in, torque_in} = '0;
    {status_flags_in, speed_in, position_in, pi_rsp_in} = {16'hFFFF, 16'h8001, 32'h4000_1234, 64'hA5A5_1111};
    {logic_supply_in, drive_supply_in, temperature_in} = {meas[0], meas[1], meas[2]};
    {switch_pins_in, build_date_in, serial_in} = {meas[3], meas[4], meas[5]};
    repeat (6) @(posedge clk_in);
    rst_in <= 1'b0;
    test_cyclic();
    test_access();
    test_config();
    test_peak();
    give_verdict();
  end
endmodule : tb
